// file: bench/dtr_regs_assertions.sv
// Concurrent checks on the timing register bank ports.
// Assumes it is bound onto dtr_regs; one clock domain.
`timescale 1ns/1ns
module dtr_regs_assertions
    import dtr_pkg::*;
(
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_we_i, // Write
    input wire logic [ADR_W-1:0] wb_adr_i, // Address
    input wire logic [3:0] wb_sel_i, // Selects
    input wire logic [DAT_W-1:0] wb_dat_i, // Write data
    input wire logic [DAT_W-1:0] wb_dat_o, // Read data
    input wire logic wb_ack_o, // Ack
    input wire logic [VAL_W-1:0] hs_prepare_time_o, // Prepare
    input wire logic [VAL_W-1:0] hs_zero_time_o, // Zero
    input wire logic [VAL_W-1:0] hs_trail_time_o, // Trail
    input wire logic [VAL_W-1:0] hs_exit_time_o, // Exit
    input wire logic [VAL_W-1:0] lp_transition_time_o, // Low power
    input wire logic [VAL_W-1:0] p1_clock_prepare_time_o, // Port 1
    input wire logic [2:0] lane_rate_o, // Rate
    input wire logic timing_change_o // Change pulse
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Taken request and applied set
    logic taken;
    logic [41:0] applied;
    assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign applied = {hs_prepare_time_o, hs_zero_time_o, hs_trail_time_o, hs_exit_time_o,
        lp_transition_time_o, p1_clock_prepare_time_o};
    sequence wr_to(idx);
        taken && wb_we_i && wb_sel_i[0] && wb_adr_i[9:2] == idx;
    endsequence
    // Bus handshake
    ack_one_a: assert property (taken |=> wb_ack_o) else $error("ack missing");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    ack_cause_a: assert property (wb_ack_o |-> $past(taken)) else $error("ack without request");
    // Register behaviour
    ov_write_a: assert property (wr_to(IDX_HS_PREP) ##0 wb_dat_i[7] |->
        ##2 hs_prepare_time_o == $past(wb_dat_i[6:0], 2)) else $error("override not applied");
    // Change pulse rises in the same cycle as the new applied set
    chg_pulse_a: assert property ($changed(applied) |-> timing_change_o) else $error("no change pulse");
    chg_cause_a: assert property (timing_change_o |-> $changed(applied)) else $error("stray change pulse");
    rate_set_a: assert property (wr_to(IDX_RATE_SEL) ##0 wb_dat_i[2:0] <= 3'h4 |=>
        lane_rate_o == $past(wb_dat_i[2:0])) else $error("rate not taken");
    rate_bad_a: assert property (wr_to(IDX_RATE_SEL) ##0 wb_dat_i[2:0] > 3'h4 |=>
        $stable(lane_rate_o)) else $error("bad rate taken");
    unmap_rd_a: assert property (taken && !wb_we_i && wb_adr_i[9:2] == 8'h00 |=>
        wb_dat_o == 32'h0) else $error("unmapped read not zero");
    reset_vals_a: assert property (disable iff (1'b0) rst_i |=>
        !wb_ack_o && !timing_change_o && lane_rate_o == 3'h1 &&
        applied == {7'h06, 7'h0c, 7'h08, 7'h0b, 7'h06, 7'h05}) else $error("bad reset");
endmodule

// file: bench/dtr_seq_model.sv
// Transmitter sequencer model that takes up applied timing values.
// Assumes values are settled when the change pulse is seen.
`timescale 1ns/1ns
module dtr_seq_model (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic [41:0] applied_i, // Applied set, prepare high
    input wire logic change_i, // Change pulse
    output logic [41:0] seen_o // Last set taken up
);
    // Latch the set on each change pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seen_o <= 42'h0;
        end else if (change_i) begin
            seen_o <= applied_i;
        end
    end
endmodule

// file: bench/tb_dtr_regs.sv
// Self-checking bench for the timing register bank.
// Assumes a 10 MHz clock and a classic Wishbone master.
`timescale 1ns/1ns
module tb_dtr_regs
    import dtr_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [ADR_W-1:0] wb_adr = 12'h0;
    logic [3:0] wb_sel = 4'h0;
    logic [DAT_W-1:0] wb_wdat = 32'h0;
    logic [DAT_W-1:0] wb_rdat;
    logic wb_ack;
    logic [VAL_W-1:0] prep, zero, trail, hexit, lp, p1ck;
    logic [2:0] rate;
    logic chg;
    logic [41:0] seen;
    logic [31:0] rd;
    int bad_count = 0;
    int cmp_count = 0;
    // Rows: op nibble (1 write, 0 read and compare), address, data
    logic [47:0] rows [27] = '{48'h0_110_00000006, 48'h0_114_0000000c, 48'h0_118_00000008,
        48'h0_11c_0000000b, 48'h0_120_00000006, 48'h0_180_00000005, 48'h1_110_00000035,
        48'h0_110_00000006, 48'h1_110_0000009a, 48'h0_110_0000009a, 48'h1_110_00000000,
        48'h0_110_00000006, 48'h1_180_00000081, 48'h0_180_00000081, 48'h1_140_00000000,
        48'h0_114_00000007, 48'h1_140_00000002, 48'h0_114_00000012, 48'h1_140_00000003,
        48'h0_114_00000016, 48'h1_140_00000004, 48'h0_114_00000018, 48'h1_140_00000007,
        48'h0_140_00000004, 48'h1_140_00000001, 48'h0_114_0000000c, 48'h0_000_00000000};
    // Clock
    always #50 clk_i = ~clk_i;
    // Design and sequencer model
    dtr_regs dtr_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .hs_prepare_time_o(prep), .hs_zero_time_o(zero), .hs_trail_time_o(trail),
        .hs_exit_time_o(hexit), .lp_transition_time_o(lp), .p1_clock_prepare_time_o(p1ck),
        .lane_rate_o(rate), .timing_change_o(chg));
    dtr_seq_model dtr_seq_model_inst (.clk_i(clk_i), .rst_i(rst_i),
        .applied_i({prep, zero, trail, hexit, lp, p1ck}), .change_i(chg), .seen_o(seen));
    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask
    // Verdict and end of run
    task automatic final_report();
        $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // One classic cycle; read data lands in rd
    task automatic bus(input logic we, input logic [11:0] adr, input logic [31:0] dat, input logic [3:0] sel);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= dat;
        wb_sel <= sel;
        while (wb_ack !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 20) begin
            bad_count++;
            final_report();
        end
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 27; i++) begin
            bus(rows[i][44], rows[i][43:32], rows[i][31:0], 4'h1);
            if (!rows[i][44]) begin
                check(rd, rows[i][31:0]);
            end
        end
        // Byte lane off, then override held across a rate change
        bus(1'b1, 12'h118, 32'h0000008f, 4'h0);
        bus(1'b0, 12'h118, 32'h0, 4'h1);
        check(rd, 32'h08);
        bus(1'b1, 12'h118, 32'h00000085, 4'h1);
        bus(1'b1, 12'h140, 32'h00000004, 4'h1);
        bus(1'b0, 12'h118, 32'h0, 4'h1);
        check(rd, 32'h85);
        check({25'h0, trail}, 32'h05);
        check({25'h0, zero}, 32'h18);
        check({25'h0, p1ck}, 32'h01);
        check({25'h0, seen[34:28]}, 32'h18);
        check({25'h0, prep}, 32'h0c);
        check({25'h0, hexit}, 32'h16);
        check({25'h0, lp}, 32'h0c);
        // Status shows trail and port 1 overrides set
        bus(1'b0, 12'h144, 32'h0, 4'h1);
        check(rd, 32'h24);
        // Second reset clears every override
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, 12'h118, 32'h0, 4'h1);
        check(rd, 32'h08);
        check({25'h0, p1ck}, 32'h05);
        check({29'h0, rate}, 32'h1);
        bus(1'b0, 12'h144, 32'h0, 4'h1);
        check(rd, 32'h0);
        final_report();
    end
endmodule
bind dtr_regs dtr_regs_assertions dtr_regs_assertions_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .hs_prepare_time_o(hs_prepare_time_o),
    .hs_zero_time_o(hs_zero_time_o), .hs_trail_time_o(hs_trail_time_o), .hs_exit_time_o(hs_exit_time_o),
    .lp_transition_time_o(lp_transition_time_o), .p1_clock_prepare_time_o(p1_clock_prepare_time_o),
    .lane_rate_o(lane_rate_o), .timing_change_o(timing_change_o));

// file: common/dtr_pkg.sv
// Constants for the D-PHY timing override register bank.
// Assumes a 32-bit classic Wishbone slave with word-aligned byte registers.
package dtr_pkg;

    // Bus geometry
    localparam int ADR_W = 12;
    localparam int DAT_W = 32;
    localparam int IDX_W = 8;
    localparam int VAL_W = 7;
    localparam int NUM_SLOT = 6;
    localparam int SLOT_W = 3;

    // Field layout of every timing register
    localparam int OV_BIT = 7;
    localparam int VAL_LSB = 0;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_HS_PREP = 8'h44;
    localparam logic [IDX_W-1:0] IDX_HS_ZERO = 8'h45;
    localparam logic [IDX_W-1:0] IDX_HS_TRAIL = 8'h46;
    localparam logic [IDX_W-1:0] IDX_HS_EXIT = 8'h47;
    localparam logic [IDX_W-1:0] IDX_LP_TRANS = 8'h48;
    localparam logic [IDX_W-1:0] IDX_RATE_SEL = 8'h50;
    localparam logic [IDX_W-1:0] IDX_STATUS = 8'h51;
    localparam logic [IDX_W-1:0] IDX_P1_CK_PREP = 8'h60;

    // Slot numbers of the timing registers
    localparam logic [SLOT_W-1:0] SLOT_HS_PREP = 3'h0;
    localparam logic [SLOT_W-1:0] SLOT_HS_ZERO = 3'h1;
    localparam logic [SLOT_W-1:0] SLOT_HS_TRAIL = 3'h2;
    localparam logic [SLOT_W-1:0] SLOT_HS_EXIT = 3'h3;
    localparam logic [SLOT_W-1:0] SLOT_LP_TRANS = 3'h4;
    localparam logic [SLOT_W-1:0] SLOT_P1_CK_PREP = 3'h5;
    localparam logic [SLOT_W-1:0] SLOT_NONE = 3'h7;

    // Reset values of the timing registers
    localparam logic [7:0] RST_HS_PREP = 8'h06;
    localparam logic [7:0] RST_HS_ZERO = 8'h0c;
    localparam logic [7:0] RST_HS_TRAIL = 8'h08;
    localparam logic [7:0] RST_HS_EXIT = 8'h0b;
    localparam logic [7:0] RST_LP_TRANS = 8'h06;
    localparam logic [7:0] RST_P1_CK_PREP = 8'h05;

    // Lane rate selection codes
    typedef enum logic [2:0] {
        RATE_400 = 3'h0,
        RATE_800 = 3'h1,
        RATE_1200 = 3'h2,
        RATE_1500 = 3'h3,
        RATE_1600 = 3'h4
    } dtr_rate_t;
    localparam dtr_rate_t RATE_RST = RATE_800;

    // Derived values per rate, slot 0 in the low bits
    localparam logic [NUM_SLOT*VAL_W-1:0] AUTO_800 = {RST_P1_CK_PREP[6:0], RST_LP_TRANS[6:0],
        RST_HS_EXIT[6:0], RST_HS_TRAIL[6:0], RST_HS_ZERO[6:0], RST_HS_PREP[6:0]};
    localparam logic [NUM_SLOT*VAL_W-1:0] AUTO_400 = {7'h03, 7'h04, 7'h06, 7'h05, 7'h07, 7'h04};
    localparam logic [NUM_SLOT*VAL_W-1:0] AUTO_1200 = {7'h07, 7'h09, 7'h10, 7'h0c, 7'h12, 7'h09};
    localparam logic [NUM_SLOT*VAL_W-1:0] AUTO_1500 = {7'h09, 7'h0b, 7'h14, 7'h0f, 7'h16, 7'h0b};
    localparam logic [NUM_SLOT*VAL_W-1:0] AUTO_1600 = {7'h0a, 7'h0c, 7'h16, 7'h10, 7'h18, 7'h0c};

endpackage

// file: rtl/dtr_auto_rom.sv
// Table of rate-derived timing values, one row per lane rate.
// Assumes the rate code is stable for a cycle; output is registered.
`timescale 1ns/1ns
module dtr_auto_rom
    import dtr_pkg::*;
(
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Synchronous reset, active high
    input wire dtr_rate_t rate_i, // Selected lane rate
    output logic [NUM_SLOT*VAL_W-1:0] auto_o // Derived values, slot 0 low
);

    logic [NUM_SLOT*VAL_W-1:0] row_d;
    logic [NUM_SLOT*VAL_W-1:0] row_q;

    // Row lookup by rate
    always_comb begin
        unique case (rate_i)
            RATE_400: row_d = AUTO_400;
            RATE_800: row_d = AUTO_800;
            RATE_1200: row_d = AUTO_1200;
            RATE_1500: row_d = AUTO_1500;
            RATE_1600: row_d = AUTO_1600;
            default: row_d = AUTO_800;
        endcase
    end

    // Registered read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            row_q <= AUTO_800;
        end else begin
            row_q <= row_d;
        end
    end

    assign auto_o = row_q;

endmodule

// file: rtl/dtr_regs.sv
// D-PHY timing override register bank behind a classic Wishbone slave.
// Assumes one 10 MHz clock, synchronous reset and a well-behaved master.
//
// Functional notes
// - Bit 7 picks automatic or register value
// - Override clear: value field reads derived value
// - Override set: field writable, read back, applied
// - Derived values follow rate; reset at 800
// - Prepare register at 0x44, reset 0x06
// - Zero register at 0x45, reset 0x0c
// - Trail register at 0x46, reset 0x08
// - Exit register at 0x47, reset 0x0b
// - Low-power transition at 0x48, reset 0x06
// - Every override bit resets to zero
// - Port 1 clock prepare at 0x60, reset 0x05
`timescale 1ns/1ns
module dtr_regs
    import dtr_pkg::*;
(
    input wire logic clk_i, // System clock, 10 MHz
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_we_i, // Write enable
    input wire logic [ADR_W-1:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte lane selects
    input wire logic [DAT_W-1:0] wb_dat_i, // Write data
    output logic [DAT_W-1:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    output logic [VAL_W-1:0] hs_prepare_time_o, // Applied HS prepare
    output logic [VAL_W-1:0] hs_zero_time_o, // Applied HS zero
    output logic [VAL_W-1:0] hs_trail_time_o, // Applied HS trail
    output logic [VAL_W-1:0] hs_exit_time_o, // Applied HS exit
    output logic [VAL_W-1:0] lp_transition_time_o, // Applied LP transition
    output logic [VAL_W-1:0] p1_clock_prepare_time_o, // Applied port 1 clock prepare
    output logic [2:0] lane_rate_o, // Selected lane rate code
    output logic timing_change_o // Pulse when any applied value changes
);

    // Maps a register index to its timing slot
    function automatic logic [SLOT_W-1:0] slot_of(input logic [IDX_W-1:0] idx);
        logic [SLOT_W-1:0] s;
        s = SLOT_NONE;
        unique case (idx)
            IDX_HS_PREP: s = SLOT_HS_PREP;
            IDX_HS_ZERO: s = SLOT_HS_ZERO;
            IDX_HS_TRAIL: s = SLOT_HS_TRAIL;
            IDX_HS_EXIT: s = SLOT_HS_EXIT;
            IDX_LP_TRANS: s = SLOT_LP_TRANS;
            IDX_P1_CK_PREP: s = SLOT_P1_CK_PREP;
            default: s = SLOT_NONE;
        endcase
        return s;
    endfunction

    // Reset value of a timing slot
    function automatic logic [7:0] rst_of(input int unsigned slot);
        logic [7:0] r;
        r = 8'h00;
        unique case (slot)
            0: r = RST_HS_PREP;
            1: r = RST_HS_ZERO;
            2: r = RST_HS_TRAIL;
            3: r = RST_HS_EXIT;
            4: r = RST_LP_TRANS;
            5: r = RST_P1_CK_PREP;
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    // Legal rate codes
    function automatic logic rate_ok(input logic [2:0] code);
        return (code <= RATE_1600);
    endfunction

    // Bus request decode
    logic req;
    logic wr_en;
    logic rd_en;
    logic [IDX_W-1:0] idx;
    logic [SLOT_W-1:0] hit_slot;
    logic ack_q;
    logic [DAT_W-1:0] rdat_q;
    logic [DAT_W-1:0] rdat_d;

    // Per-slot state
    logic [NUM_SLOT-1:0] ov_q;
    logic [VAL_W-1:0] val_q [NUM_SLOT];
    logic [VAL_W-1:0] applied_q [NUM_SLOT];
    logic [VAL_W-1:0] applied_d [NUM_SLOT];
    logic [VAL_W-1:0] auto_val [NUM_SLOT];
    logic [NUM_SLOT*VAL_W-1:0] auto_bus;
    logic [NUM_SLOT-1:0] slot_diff;

    // Rate and status state
    dtr_rate_t rate_q;
    logic settle_q;
    logic change_q;

    // A request is taken once, in the cycle before ack rises
    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_en = req && wb_we_i && wb_sel_i[0];
    assign rd_en = req && !wb_we_i;
    assign idx = wb_adr_i[IDX_W+1:2];
    assign hit_slot = slot_of(idx);

    // Derived value table, registered inside
    dtr_auto_rom u_auto_rom (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .rate_i(rate_q),
        .auto_o(auto_bus)
    );

    // Lane rate select register; illegal codes are ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rate_q <= RATE_RST;
        end else if (wr_en && idx == IDX_RATE_SEL && rate_ok(wb_dat_i[2:0])) begin
            rate_q <= dtr_rate_t'(wb_dat_i[2:0]);
        end
    end

    // Marks the cycle in which the table row is still catching up
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            settle_q <= 1'b0;
        end else begin
            settle_q <= wr_en && idx == IDX_RATE_SEL && rate_ok(wb_dat_i[2:0]);
        end
    end

    // Timing slots: override bit, held value and applied value
    genvar g;
    generate
        for (g = 0; g < NUM_SLOT; g++) begin : g_slot
            assign auto_val[g] = auto_bus[g*VAL_W +: VAL_W];

            // Override bit and software value
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    ov_q[g] <= 1'b0;
                    val_q[g] <= VAL_W'(rst_of(g));
                end else if (wr_en && hit_slot == SLOT_W'(g)) begin
                    ov_q[g] <= wb_dat_i[OV_BIT];
                    if (wb_dat_i[OV_BIT]) begin
                        val_q[g] <= wb_dat_i[VAL_LSB +: VAL_W];
                    end
                end
            end

            // Source select for the applied parameter
            assign applied_d[g] = ov_q[g] ? val_q[g] : auto_val[g];
            assign slot_diff[g] = applied_d[g] != applied_q[g];

            // Applied parameter register
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    applied_q[g] <= VAL_W'(rst_of(g));
                end else begin
                    applied_q[g] <= applied_d[g];
                end
            end
        end
    endgenerate

    // Change pulse toward the transmitter sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            change_q <= 1'b0;
        end else begin
            change_q <= |slot_diff;
        end
    end

    // Read data selection
    always_comb begin
        rdat_d = '0;
        if (hit_slot != SLOT_NONE) begin
            rdat_d[OV_BIT] = ov_q[hit_slot];
            if (ov_q[hit_slot]) begin
                rdat_d[VAL_LSB +: VAL_W] = val_q[hit_slot];
            end else begin
                rdat_d[VAL_LSB +: VAL_W] = auto_val[hit_slot];
            end
        end else if (idx == IDX_RATE_SEL) begin
            rdat_d[2:0] = rate_q;
        end else if (idx == IDX_STATUS) begin
            rdat_d[NUM_SLOT-1:0] = ov_q;
            rdat_d[8] = settle_q;
        end
    end

    // Acknowledge: one cycle after the request, dropped the next
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    // Read data register, zero for writes and unmapped reads
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= '0;
        end else if (rd_en) begin
            rdat_q <= rdat_d;
        end else if (req) begin
            rdat_q <= '0;
        end
    end

    // Outputs, all straight from registers
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign hs_prepare_time_o = applied_q[SLOT_HS_PREP];
    assign hs_zero_time_o = applied_q[SLOT_HS_ZERO];
    assign hs_trail_time_o = applied_q[SLOT_HS_TRAIL];
    assign hs_exit_time_o = applied_q[SLOT_HS_EXIT];
    assign lp_transition_time_o = applied_q[SLOT_LP_TRANS];
    assign p1_clock_prepare_time_o = applied_q[SLOT_P1_CK_PREP];
    assign lane_rate_o = rate_q;
    assign timing_change_o = change_q;

endmodule
